// ---- sim/ddcb_properties.sv ----
`default_nettype none
module ddcb_chk
   import ddcb_pkg::*;
(
   input wire logic             pclk,          // clock
   input wire logic             presetn,       // reset, low
   input wire logic             reg_req,       // reg request
   input wire logic             reg_we,        // reg write
   input wire logic [11:0]      reg_addr,      // reg address
   input wire logic [31:0]      reg_wdata,     // reg data
   input wire logic             reg_ack,       // reg answer
   input wire logic             serial_link_enable,    // link on
   input wire logic             power_down_first_adc,  // adc a off
   input wire logic             power_down_second_adc, // adc b off
   input wire logic             mode_64b66b,   // coding
   input wire logic             sync_req_n,    // sync request
   input wire logic             sysref,        // sysref pulse
   input wire logic             smp_valid,     // sample valid
   input wire logic [SMP_W-1:0] smp_data,      // sample pair
   input wire logic             smp_ready,     // sample accept
   input wire logic             dig_pd_a,      // channel a off
   input wire logic             dig_pd_b       // channel b off
);
   logic [1:0] bnd_ff;
   logic [1:0] cnt_ff;
   // binding as last written over the register port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) bnd_ff <= RST_BIND[1:0];
      else if (reg_req && reg_we && reg_addr == ADDR_BIND) bnd_ff <= reg_wdata[1:0];
   end
   // cycles since any register request or power-down input move
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_ff <= 2'h0;
      else if (reg_req || $changed(power_down_first_adc) || $changed(power_down_second_adc))
         cnt_ff <= 2'h0;
      else if (cnt_ff != 2'h3) cnt_ff <= cnt_ff + 2'h1;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ack_one_later: assert property (reg_req |=> reg_ack) else $error("ack missing");
   a_ack_has_req: assert property (reg_ack |-> $past(reg_req)) else $error("stray ack");
   a_req_single: assert property (reg_req |=> !reg_req) else $error("req too long");
   a_smp_held: assert property (smp_valid && !smp_ready |=> smp_valid && $stable(smp_data))
      else $error("sample dropped");
   a_pop_gated: assert property ($rose(smp_valid) |-> $past(serial_link_enable) &&
      ($past(mode_64b66b) || $past(sync_req_n))) else $error("link not stalled");
   a_sysref_pulse: assert property (sysref |=> !sysref) else $error("sysref too long");
   a_pd_a_bound: assert property (cnt_ff == 2'h3 |->
      dig_pd_a == (bnd_ff[0] ? $past(power_down_second_adc) : $past(power_down_first_adc)))
      else $error("channel a power wrong");
   a_pd_b_bound: assert property (cnt_ff == 2'h3 |->
      dig_pd_b == (bnd_ff[1] ? $past(power_down_second_adc) : $past(power_down_first_adc)))
      else $error("channel b power wrong");
   c_sysref: cover property (sysref);
   c_smp64: cover property ($rose(smp_valid) && mode_64b66b);
   c_pd_both: cover property (dig_pd_a && dig_pd_b);
endmodule : ddcb_chk
`default_nettype wire

// ---- sim/test_ddc_binding_and_oscillator_phase_sync_control_ctrl.sv ----
`default_nettype none
module test_ddc_binding_and_oscillator_phase_sync_control_ctrl
   import ddcb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic adc_valid = 1'h0, out_ready = 1'h0, pready, pslverr, adc_ready, out_valid, err;
   logic phase_init, nco_armed;
   logic [11:0] paddr = 12'h0, adc_a = 12'h0, adc_b = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd, nco_phase, ph0;
   logic [SMP_W-1:0] out_data;
   int n_errors = 0, samples_checked = 0, n_init = 0;
   ddcb_if ifc ();
   ddcb_dev u_ddcb_dev (.pclk, .presetn, .bus(ifc.dev), .adc_valid, .adc_ready, .adc_a,
      .adc_b, .nco_phase, .phase_init, .nco_armed);
   ddcb_host u_ddcb_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .bus(ifc.host), .out_valid, .out_ready, .out_data);
   ddcb_chk u_ddcb_chk (.pclk, .presetn, .reg_req(ifc.reg_req), .reg_we(ifc.reg_we),
      .reg_addr(ifc.reg_addr), .reg_wdata(ifc.reg_wdata), .reg_ack(ifc.reg_ack),
      .serial_link_enable(ifc.serial_link_enable), .mode_64b66b(ifc.mode_64b66b),
      .power_down_first_adc(ifc.power_down_first_adc), .sysref(ifc.sysref),
      .power_down_second_adc(ifc.power_down_second_adc), .sync_req_n(ifc.sync_req_n),
      .smp_valid(ifc.smp_valid), .smp_data(ifc.smp_data), .smp_ready(ifc.smp_ready),
      .dig_pd_a(ifc.dig_pd_a), .dig_pd_b(ifc.dig_pd_b));
   always #20 pclk = ~pclk;
   always @(negedge pclk) if (phase_init === 1'h1) n_init++;
   task chk(input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask : chk
   task finish_test;
      if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   // device access through the command register, result left in rd
   task dev(input logic w, input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, APB_WDATA, d);
      apb(1'h1, APB_CMD, {15'h0, w, 4'h0, a});
      do apb(1'h0, APB_STATUS, 32'h0); while (rd[STS_BUSY] !== 1'h0);
      apb(1'h0, APB_RDATA, 32'h0);
   endtask : dev
   task t_path(input logic [1:0] b, input int cnt);
      int n;
      int j;
      n = 0;
      apb(1'h1, APB_CTRL, 32'h40);
      dev(1'h1, ADDR_BIND, 32'(b));
      apb(1'h1, APB_CTRL, 32'h41);
      adc_a <= 12'h0;
      adc_b <= 12'h800;
      adc_valid <= 1'h1;
      repeat (cnt) begin
         @(negedge pclk);
         if (adc_ready === 1'h1) n++;
         @(posedge pclk);
         adc_a <= n[11:0];
         adc_b <= 12'h800 | n[11:0];
      end
      adc_valid <= 1'h0;
      out_ready <= 1'h1;
      chk(32'(n), cnt > 10 ? 32'ha : 32'(cnt));
      for (j = 0; j < n; j++) begin
         do @(negedge pclk); while (out_valid !== 1'h1);
         chk(32'(out_data[23:12]), 32'(b[1] ? 12'h800 | j[11:0] : j[11:0]));
         chk(32'(out_data[11:0]), 32'(b[0] ? 12'h800 | j[11:0] : j[11:0]));
         @(posedge pclk);
      end
      out_ready <= 1'h0;
   endtask : t_path
   task t_sync(input logic m);
      int k;
      dev(1'h1, ADDR_SYNC, 32'h2);
      apb(1'h1, APB_CTRL, {27'h0, m, 4'h1});
      k = n_init;
      apb(1'h1, APB_CTRL, {26'h2, m, 4'h1});
      repeat (40) @(negedge pclk);
      chk(32'(n_init - k), 32'h1);
   endtask : t_sync
   initial begin
      int k;
      int i;
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, APB_CTRL, 32'h0);
      chk(rd, 32'(RST_CTRL));
      apb(1'h0, 12'h018, 32'h0);
      chk(32'(err), 32'h1);
      dev(1'h0, ADDR_BIND, 32'h0);
      chk(rd, 32'(RST_BIND));
      dev(1'h0, ADDR_SYNC, 32'h0);
      chk(rd, 32'(RST_SYNC));
      dev(1'h0, ADDR_FREQ0, 32'h0);
      chk(rd, RST_FREQ0);
      t_path(2'h2, 20);
      for (i = 0; i < 4; i++) begin
         t_path(i[1:0], 1);
         apb(1'h1, APB_CTRL, 32'h48);
         apb(1'h0, APB_STATUS, 32'h0);
         chk(32'(rd[3:2]), 32'(i));
         apb(1'h1, APB_CTRL, 32'h44);
         apb(1'h0, APB_STATUS, 32'h0);
         chk(32'(rd[3:2]), 32'(3 - i));
      end
      apb(1'h1, APB_CTRL, 32'h41);
      dev(1'h1, ADDR_BIND, 32'h2);
      apb(1'h0, APB_STATUS, 32'h0);
      chk(32'(rd[STS_ERR]), 32'h1);
      apb(1'h1, APB_STATUS, 32'h2);
      dev(1'h1, ADDR_RDIV, 32'h2001);
      dev(1'h0, ADDR_RDIV, 32'h0);
      chk(rd, 32'h0);
      dev(1'h1, ADDR_RDIV, 32'h2000);
      dev(1'h0, ADDR_RDIV, 32'h0);
      chk(rd, 32'h2000);
      dev(1'h1, ADDR_RDIV, 32'h0);
      @(negedge pclk);
      ph0 = nco_phase;
      @(negedge pclk);
      chk(nco_phase - ph0, RST_FREQ0);
      dev(1'h1, ADDR_SYNC, 32'h1);
      chk(32'(nco_armed), 32'h0);
      dev(1'h1, ADDR_SYNC, 32'h0);
      dev(1'h1, ADDR_SYNC, 32'h1);
      chk(32'(nco_armed), 32'h1);
      k = n_init;
      apb(1'h1, APB_SYSREF, 32'h0);
      repeat (6) @(negedge pclk);
      chk(32'(n_init - k), 32'h1);
      chk(32'(nco_armed), 32'h0);
      apb(1'h1, APB_SYSREF, 32'h0);
      repeat (6) @(negedge pclk);
      chk(32'(n_init - k), 32'h1);
      dev(1'h1, ADDR_FREQ0, 32'h0);
      dev(1'h1, ADDR_PHASE0, 32'h1234);
      t_sync(1'h0);
      chk(nco_phase, 32'h12340000);
      t_sync(1'h1);
      finish_test;
   end
   initial begin
      #800000;
      n_errors++;
      finish_test;
   end
endmodule : test_ddc_binding_and_oscillator_phase_sync_control_ctrl
`default_nettype wire

// ---- src/ddcb_dev.sv ----
`default_nettype none
module ddcb_dev
   import ddcb_pkg::*;
(
   input  wire logic             pclk,       // device clock
   input  wire logic             presetn,    // async reset, low
   ddcb_if.dev                   bus,        // registers and link
   input  wire logic             adc_valid,  // adc sample pair valid
   output logic                  adc_ready,  // sample fifo not full
   input  wire logic [ADC_W-1:0] adc_a,      // first adc sample
   input  wire logic [ADC_W-1:0] adc_b,      // second adc sample
   output logic [31:0]           nco_phase,  // oscillator phase
   output logic                  phase_init, // phase initialised pulse
   output logic                  nco_armed   // sysref init armed
);
   logic [7:0]       bind_ff;
   logic [15:0]      rdiv_ff;
   logic [7:0]       sync_ff;
   logic [31:0]      freq_ff;
   logic [15:0]      phw_ff;
   logic             ack_ff;
   logic [31:0]      rdata_ff;
   logic             zero_seen_ff;
   logic             armed_ff;
   logic             nxt_armed;
   logic             pend_ff;
   logic             syncn_q_ff;
   logic             sysref_q_ff;
   logic [$clog2(MF_LEN)-1:0] mf_ff;
   logic [31:0]      acc_ff;
   logic [31:0]      nxt_acc;
   logic [31:0]      phase_ff;
   logic             init_ff;
   logic             out_vld_ff;
   logic [SMP_W-1:0] out_dat_ff;
   logic             pda_ff;
   logic             pdb_ff;
   logic             fifo_vld;
   logic [SMP_W-1:0] fifo_dat;
   logic             fifo_pop;
   logic             wr;
   logic             sync_rise;
   logic             sysref_rise;
   logic             boundary;
   logic             init_now;
   logic             link_go;
   logic             nxt_pda;
   logic             nxt_pdb;
   logic [ADC_W-1:0] nxt_dig_a;
   logic [ADC_W-1:0] nxt_dig_b;
   logic [32:0]      sum;
   logic [32:0]      modulus;

   assign wr          = bus.reg_req & bus.reg_we;
   assign sync_rise   = bus.sync_req_n & ~syncn_q_ff;
   assign sysref_rise = bus.sysref & ~sysref_q_ff;
   assign boundary    = (mf_ff == ($clog2(MF_LEN))'(MF_LEN - 1));

   // register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bind_ff <= RST_BIND;
         rdiv_ff <= RST_RDIV;
         sync_ff <= RST_SYNC;
         freq_ff <= RST_FREQ0;
         phw_ff  <= RST_PHASE0;
      end else if (wr) begin
         case (bus.reg_addr)
            ADDR_BIND:   bind_ff <= bus.reg_wdata[7:0];
            ADDR_RDIV:   rdiv_ff <= bus.reg_wdata[15:0];
            ADDR_SYNC:   sync_ff <= bus.reg_wdata[7:0];
            ADDR_FREQ0:  freq_ff <= bus.reg_wdata;
            ADDR_PHASE0: phw_ff  <= bus.reg_wdata[15:0];
            default: begin
            end
         endcase
      end
   end

   // register reads, answered one cycle after the request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_ff   <= 1'b0;
         rdata_ff <= '0;
      end else begin
         ack_ff <= bus.reg_req;
         if (bus.reg_req && !bus.reg_we) begin
            case (bus.reg_addr)
               ADDR_BIND:   rdata_ff <= {24'h0, bind_ff};
               ADDR_RDIV:   rdata_ff <= {16'h0, rdiv_ff};
               ADDR_SYNC:   rdata_ff <= {24'h0, sync_ff};
               ADDR_FREQ0:  rdata_ff <= freq_ff;
               ADDR_PHASE0: rdata_ff <= {16'h0, phw_ff};
               default:     rdata_ff <= '0;
            endcase
         end
      end
   end

   // edge history of the link strobes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         syncn_q_ff  <= 1'b1;
         sysref_q_ff <= 1'b0;
      end else begin
         syncn_q_ff  <= bus.sync_req_n;
         sysref_q_ff <= bus.sysref;
      end
   end

   // multiframe boundary counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mf_ff <= '0;
      end else begin
         mf_ff <= boundary ? '0 : mf_ff + ($clog2(MF_LEN))'(1);
      end
   end

   // sync-request init waits for the next boundary; set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_ff <= 1'b0;
      end else if (sync_rise && sync_ff[BIT_SYNC_REQ]) begin
         pend_ff <= 1'b1;
      end else if (boundary) begin
         pend_ff <= 1'b0;
      end
   end

   // next-sysref arming: a 0 write, then a 1 write
   always_comb begin
      nxt_armed = armed_ff;
      if (armed_ff && sysref_rise) begin
         nxt_armed = 1'b0;
      end
      if (wr && bus.reg_addr == ADDR_SYNC && bus.reg_wdata[BIT_SYNC_NXT] && zero_seen_ff) begin
         nxt_armed = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_ff     <= 1'b0;
         zero_seen_ff <= 1'b0;
      end else begin
         armed_ff <= nxt_armed;
         if (wr && bus.reg_addr == ADDR_SYNC) begin
            zero_seen_ff <= ~bus.reg_wdata[BIT_SYNC_NXT];
         end
      end
   end

   assign init_now = (pend_ff & boundary) | (armed_ff & sysref_rise);

   // phase accumulator, optionally modulo the reference divisor
   always_comb begin
      sum     = {1'b0, acc_ff} + {1'b0, freq_ff};
      modulus = {1'b0, rdiv_ff, 16'h0};
      nxt_acc = sum[31:0];
      if (rdiv_ff != 16'h0 && sum >= modulus) begin
         nxt_acc = 32'(sum - modulus);
      end
      if (init_now) begin
         nxt_acc = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_ff   <= '0;
         phase_ff <= '0;
         init_ff  <= 1'b0;
      end else begin
         acc_ff   <= nxt_acc;
         phase_ff <= nxt_acc + {phw_ff, 16'h0};
         init_ff  <= init_now;
      end
   end

   // channel binding and power-down
   always_comb begin
      nxt_pda   = bind_ff[BIT_BIND_A] ? bus.power_down_second_adc
                                      : bus.power_down_first_adc;
      nxt_pdb   = bind_ff[BIT_BIND_B] ? bus.power_down_second_adc
                                      : bus.power_down_first_adc;
      nxt_dig_a = bind_ff[BIT_BIND_A] ? fifo_dat[SMP_W-1:ADC_W] : fifo_dat[ADC_W-1:0];
      nxt_dig_b = bind_ff[BIT_BIND_B] ? fifo_dat[SMP_W-1:ADC_W] : fifo_dat[ADC_W-1:0];
      if (nxt_pda) begin
         nxt_dig_a = '0;
      end
      if (nxt_pdb) begin
         nxt_dig_b = '0;
      end
   end

   // in 64b/66b the sync request never holds the link
   assign link_go  = bus.serial_link_enable & ~(nxt_pda & nxt_pdb)
                   & (bus.mode_64b66b | bus.sync_req_n);
   assign fifo_pop = fifo_vld & link_go & (~out_vld_ff | bus.smp_ready);

   ddcb_fifo #(
      .W (SMP_W),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (adc_valid),
      .in_ready  (adc_ready),
      .in_data   ({adc_b, adc_a}),
      .out_valid (fifo_vld),
      .out_ready (fifo_pop),
      .out_data  (fifo_dat)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_vld_ff <= 1'b0;
         out_dat_ff <= '0;
         pda_ff     <= 1'b0;
         pdb_ff     <= 1'b0;
      end else begin
         pda_ff <= nxt_pda;
         pdb_ff <= nxt_pdb;
         if (fifo_pop) begin
            out_vld_ff <= 1'b1;
            out_dat_ff <= {nxt_dig_b, nxt_dig_a};
         end else if (bus.smp_ready) begin
            out_vld_ff <= 1'b0;
         end
      end
   end

   assign bus.reg_ack   = ack_ff;
   assign bus.reg_rdata = rdata_ff;
   assign bus.smp_valid = out_vld_ff;
   assign bus.smp_data  = out_dat_ff;
   assign bus.dig_pd_a  = pda_ff;
   assign bus.dig_pd_b  = pdb_ff;
   assign nco_phase     = phase_ff;
   assign phase_init    = init_ff;
   assign nco_armed     = armed_ff;
endmodule : ddcb_dev
`default_nettype wire

// ---- src/ddcb_fifo.sv ----
`default_nettype none
module ddcb_fifo #(
   parameter int W = 24,
   parameter int D = 8
) (
   input  wire logic         pclk,      // clock
   input  wire logic         presetn,   // async reset, low
   input  wire logic         in_valid,  // write request
   output logic              in_ready,  // not full
   input  wire logic [W-1:0] in_data,   // write word
   output logic              out_valid, // not empty
   input  wire logic         out_ready, // read accept
   output logic [W-1:0]      out_data   // head word
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem [D];
   logic [AW-1:0] wp_ff;
   logic [AW-1:0] rp_ff;
   logic [AW:0]   cnt_ff;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_ff != (AW+1)'(D));
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem[rp_ff];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge pclk) begin
      if (push) begin
         mem[wp_ff] <= in_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wp_ff <= (wp_ff == AW'(D - 1)) ? '0 : wp_ff + AW'(1);
         end
         if (pop) begin
            rp_ff <= (rp_ff == AW'(D - 1)) ? '0 : rp_ff + AW'(1);
         end
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : ddcb_fifo
`default_nettype wire

// ---- src/ddcb_host.sv ----
`default_nettype none
module ddcb_host
   import ddcb_pkg::*;
(
   input  wire logic        pclk,      // clock
   input  wire logic        presetn,   // async reset, low
   input  wire logic        psel,      // apb select
   input  wire logic        penable,   // apb enable
   input  wire logic        pwrite,    // apb direction
   input  wire logic [11:0] paddr,     // apb byte address
   input  wire logic [31:0] pwdata,    // apb write data
   output logic [31:0]      prdata,    // apb read data
   output logic             pready,    // apb ready
   output logic             pslverr,   // apb error
   ddcb_if.host             bus,       // to the converter
   output logic             out_valid, // sample pair valid
   input  wire logic        out_ready, // sample pair accept
   output logic [SMP_W-1:0] out_data   // {channel b, channel a}
);
   logic [6:0]       ctrl_ff;
   logic [31:0]      wdat_ff;
   logic [31:0]      rdat_ff;
   logic             err_ff;
   ddcb_acc_e        st_ff;
   logic             req_ff;
   logic             we_ff;
   logic [11:0]      addr_ff;
   logic             sysref_ff;
   logic             rdy_ff;
   logic [31:0]      prd_ff;
   logic             perr_ff;
   logic             uv_ff;
   logic [SMP_W-1:0] ud_ff;
   logic             apb_wr;
   logic             cmd_go;
   logic             cmd_bad;
   logic             sref_bad;
   logic             mapped;

   assign apb_wr  = psel & penable & rdy_ff & pwrite;
   assign mapped  = paddr inside {APB_CTRL, APB_CMD, APB_WDATA, APB_RDATA, APB_STATUS,
                                  APB_SYSREF};
   assign cmd_bad = pwdata[CMD_WE] &
                    (((pwdata[11:0] == ADDR_BIND) &
                      (ctrl_ff[CTL_LINK] | ctrl_ff[CTL_CAL])) |
                     ((pwdata[11:0] == ADDR_BIND) & ctrl_ff[CTL_SINGLE] &
                      (wdat_ff[7:0] != RST_BIND)) |
                     ((pwdata[11:0] == ADDR_RDIV) & (wdat_ff[15:0] > RDIV_MAX)));
   assign cmd_go   = apb_wr & (paddr == APB_CMD) & (st_ff == ACC_IDLE) & ~cmd_bad;
   assign sref_bad = ~ctrl_ff[CTL_LINK] | ctrl_ff[CTL_PDA] & ctrl_ff[CTL_PDB];

   // apb slave: access phase ends one cycle after it starts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdy_ff  <= 1'b0;
         prd_ff  <= '0;
         perr_ff <= 1'b0;
      end else if (psel && penable && !rdy_ff) begin
         rdy_ff  <= 1'b1;
         perr_ff <= ~mapped;
         case (paddr)
            APB_CTRL:   prd_ff <= {25'h0, ctrl_ff};
            APB_CMD:    prd_ff <= {15'h0, we_ff, 4'h0, addr_ff};
            APB_WDATA:  prd_ff <= wdat_ff;
            APB_RDATA:  prd_ff <= rdat_ff;
            APB_STATUS: prd_ff <= {28'h0, bus.dig_pd_b, bus.dig_pd_a, err_ff,
                                   st_ff == ACC_WAIT};
            default:    prd_ff <= '0;
         endcase
      end else begin
         rdy_ff  <= 1'b0;
         perr_ff <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= RST_CTRL;
         wdat_ff <= '0;
      end else if (apb_wr) begin
         if (paddr == APB_CTRL) begin
            ctrl_ff <= pwdata[6:0];
         end
         if (paddr == APB_WDATA) begin
            wdat_ff <= pwdata;
         end
      end
   end

   // sticky error, write 1 to clear; a new error wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_ff <= 1'b0;
      end else if (apb_wr && ((paddr == APB_CMD && (st_ff != ACC_IDLE || cmd_bad)) ||
                              (paddr == APB_SYSREF && sref_bad))) begin
         err_ff <= 1'b1;
      end else if (apb_wr && paddr == APB_STATUS && pwdata[STS_ERR]) begin
         err_ff <= 1'b0;
      end
   end

   // device register access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff   <= ACC_IDLE;
         req_ff  <= 1'b0;
         we_ff   <= 1'b0;
         addr_ff <= '0;
         rdat_ff <= '0;
      end else begin
         req_ff <= cmd_go;
         case (st_ff)
            ACC_IDLE: begin
               if (cmd_go) begin
                  st_ff   <= ACC_WAIT;
                  we_ff   <= pwdata[CMD_WE];
                  addr_ff <= pwdata[11:0];
               end
            end
            ACC_WAIT: begin
               if (bus.reg_ack) begin
                  st_ff <= ACC_IDLE;
                  if (!we_ff) begin
                     rdat_ff <= bus.reg_rdata;
                  end
               end
            end
            default: st_ff <= ACC_IDLE;
         endcase
      end
   end

   // one sysref pulse per write, none while the link is off or both ADCs are powered down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sysref_ff <= 1'b0;
      end else begin
         sysref_ff <= apb_wr & (paddr == APB_SYSREF) & ~sref_bad;
      end
   end

   // sample slot toward the user
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uv_ff <= 1'b0;
         ud_ff <= '0;
      end else if (!uv_ff) begin
         uv_ff <= bus.smp_valid;
         ud_ff <= bus.smp_data;
      end else if (out_ready) begin
         uv_ff <= 1'b0;
      end
   end

   assign prdata                    = prd_ff;
   assign pready                    = rdy_ff;
   assign pslverr                   = perr_ff;
   assign bus.reg_req               = req_ff;
   assign bus.reg_we                = we_ff;
   assign bus.reg_addr              = addr_ff;
   assign bus.reg_wdata             = wdat_ff;
   assign bus.serial_link_enable    = ctrl_ff[CTL_LINK];
   assign bus.cal_enable            = ctrl_ff[CTL_CAL];
   assign bus.power_down_first_adc  = ctrl_ff[CTL_PDA];
   assign bus.power_down_second_adc = ctrl_ff[CTL_PDB];
   assign bus.mode_64b66b           = ctrl_ff[CTL_M64];
   assign bus.sync_req_n            = ctrl_ff[CTL_SYNCN];
   assign bus.sysref                = sysref_ff;
   assign bus.smp_ready             = ~uv_ff;
   assign out_valid                 = uv_ff;
   assign out_data                  = ud_ff;
endmodule : ddcb_host
`default_nettype wire

// ---- src/ddcb_if.sv ----
`default_nettype none
interface ddcb_if;
   import ddcb_pkg::*;
   logic             reg_req;
   logic             reg_we;
   logic [11:0]      reg_addr;
   logic [31:0]      reg_wdata;
   logic             reg_ack;
   logic [31:0]      reg_rdata;
   logic             serial_link_enable;
   logic             cal_enable;
   logic             power_down_first_adc;
   logic             power_down_second_adc;
   logic             mode_64b66b;
   logic             sync_req_n;
   logic             sysref;
   logic             smp_valid;
   logic [SMP_W-1:0] smp_data;
   logic             smp_ready;
   logic             dig_pd_a;
   logic             dig_pd_b;
   modport dev (input reg_req, reg_we, reg_addr, reg_wdata, serial_link_enable, cal_enable,
                power_down_first_adc, power_down_second_adc, mode_64b66b, sync_req_n,
                sysref, smp_ready,
                output reg_ack, reg_rdata, smp_valid, smp_data, dig_pd_a, dig_pd_b);
   modport host (output reg_req, reg_we, reg_addr, reg_wdata, serial_link_enable, cal_enable,
                 power_down_first_adc, power_down_second_adc, mode_64b66b, sync_req_n,
                 sysref, smp_ready,
                 input reg_ack, reg_rdata, smp_valid, smp_data, dig_pd_a, dig_pd_b);
endinterface : ddcb_if
`default_nettype wire

// ---- src/ddcb_pkg.sv ----
// Overview of operation
// - second digital channel source follows bind bit 1
// - first digital channel source follows bind bit 0
// - single-channel mode keeps the reset binding
// - link and calibration off before rebinding
// - channel powers down with its bound ADC
// - zero divisor gives plain 32-bit accumulator
// - divisor above 8192 not recommended; the controller rejects such writes
// - one divisor serves every preset
// - only integer divisors are supported
// - sync-request rise inits phase at boundary
// - sync-request init in both codings
// - write 0 then 1 arms SYSREF init
// - later SYSREF edges ignored until rearmed
// - link up and SYSREF idle before arming
// - multi-part: clear sync-request init, then arm
// - source sends SYSREF; first rise aligns
// - phase word left-justified, added to accumulator
// - resync after changing a frequency word
`default_nettype none
package ddcb_pkg;
   localparam int          ADC_W        = 12;
   localparam int          SMP_W        = 2 * ADC_W;
   localparam int          FIFO_DEPTH   = 8;
   localparam int          MF_LEN       = 32;
   // device register map
   localparam logic [11:0] ADDR_BIND    = 12'h216;
   localparam logic [11:0] ADDR_RDIV    = 12'h217;
   localparam logic [11:0] ADDR_SYNC    = 12'h219;
   localparam logic [11:0] ADDR_FREQ0   = 12'h220;
   localparam logic [11:0] ADDR_PHASE0  = 12'h224;
   localparam logic [7:0]  RST_BIND     = 8'h02;
   localparam logic [15:0] RST_RDIV     = 16'h0000;
   localparam logic [7:0]  RST_SYNC     = 8'h02;
   localparam logic [31:0] RST_FREQ0    = 32'hc0000000;
   localparam logic [15:0] RST_PHASE0   = 16'h0000;
   localparam int          BIT_BIND_A   = 0;
   localparam int          BIT_BIND_B   = 1;
   localparam int          BIT_SYNC_NXT = 0;
   localparam int          BIT_SYNC_REQ = 1;
   localparam logic [15:0] RDIV_MAX     = 16'h2000;
   // controller APB map
   localparam logic [11:0] APB_CTRL     = 12'h000;
   localparam logic [11:0] APB_CMD      = 12'h004;
   localparam logic [11:0] APB_WDATA    = 12'h008;
   localparam logic [11:0] APB_RDATA    = 12'h00c;
   localparam logic [11:0] APB_STATUS   = 12'h010;
   localparam logic [11:0] APB_SYSREF   = 12'h014;
   localparam logic [6:0]  RST_CTRL     = 7'h40;
   localparam int          CTL_LINK     = 0;
   localparam int          CTL_CAL      = 1;
   localparam int          CTL_PDA      = 2;
   localparam int          CTL_PDB      = 3;
   localparam int          CTL_M64      = 4;
   localparam int          CTL_SINGLE   = 5;
   localparam int          CTL_SYNCN    = 6;
   localparam int          CMD_WE       = 16;
   localparam int          STS_BUSY     = 0;
   localparam int          STS_ERR      = 1;
   typedef enum logic {ACC_IDLE, ACC_WAIT} ddcb_acc_e;
endpackage : ddcb_pkg
`default_nettype wire
